// file: dv/ext_irq_monitor.sv
// Port checker for the pin interrupt block.
`include "ext_irq_consts.svh"
module ext_irq_monitor
  import ext_irq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        core_irq,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [7:0]  awaddr,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr;
    awvalid && awready && wvalid && wready && wstrb[0];
  endsequence
  sequence s_rd;
    arvalid && arready;
  endsequence
  property p_rd_upper;
    rvalid |-> rdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper read bits not zero");
  property p_rd_stat;
    s_rd ##0 araddr == `OFF_IRQ_STATUS |=> rvalid && rdata[31:5] == 27'h0;
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("status read has stray bits");
  property p_rd_bad;
    s_rd ##0 araddr == 8'h40 |=> rvalid && rresp == `RESP_SLVERR
      && rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_wr_bad;
    s_wr ##0 awaddr == 8'h40 |-> ##[1:2] (bvalid && bresp == `RESP_SLVERR);
  endproperty
  a_wr_bad: assert property (p_wr_bad)
    else $error("unmapped write not refused");
  property p_gie_off;
    s_wr ##0 (awaddr == `OFF_PRIMARY_CTRL && !wdata[0])
      |-> ##3 !core_irq [*2];
  endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("request with global enable off");
  property p_mask_off;
    s_wr ##0 (awaddr == `OFF_IRQ_MASK && wdata[4:0] == 5'h00)
      |-> ##3 !core_irq [*2];
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("request with all sources disabled");
  property p_pri_bit7;
    s_rd ##0 araddr == `OFF_PRIMARY_CTRL |=> !rdata[7];
  endproperty
  a_pri_bit7: assert property (p_pri_bit7)
    else $error("primary bit 7 not zero");
  property p_irq_rst;
    $rose(nrst) |-> !core_irq ##1 !core_irq;
  endproperty
  a_irq_rst: assert property (p_irq_rst)
    else $error("request right after reset");
endmodule

bind ext_irq_ctrl ext_irq_monitor u_mon (
  .core_clk(core_clk), .nrst(nrst), .core_irq(core_irq),
  .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
  .bvalid(bvalid), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .araddr(araddr), .rvalid(rvalid),
  .rdata(rdata), .rresp(rresp));

// file: dv/external_pin_interrupt_control_tb.sv
// Self-checking bench for the pin interrupt block.
`include "ext_irq_consts.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module external_pin_interrupt_control_tb
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, pin_in;
  logic        awready, wready, bvalid, arready, rvalid, core_irq;
  logic        comp0_event;
  logic [1:0]  bresp, rresp, cc;
  int          num_errors, tests_run;

  ext_irq_ctrl #(.FOUR_PIN(1'b1)) DUT (
    .core_clk(core_clk), .nrst(nrst), .pin_in(pin_in),
    .comp0_event(comp0_event), .core_irq(core_irq),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  pin_partner u_pins (.core_clk(core_clk), .core_irq(core_irq),
    .pin_in(pin_in), .comp0_event(comp0_event));

  task automatic end_sim();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge core_clk);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d;
    wstrb <= 4'hF;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin awvalid <= 1'b0; ad = 1; end
      if (wvalid && wready) begin wvalid <= 1'b0; wd = 1; end
    end
    bready <= 1'b1;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge core_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge core_clk);
    `CHK("core_irq", e, core_irq)
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'h0; num_errors = 0; tests_run = 0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, `RESP_OKAY);
    wr(`OFF_EDGE_SELECT, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`OFF_EDGE_SELECT, 32'h000000FF, `RESP_OKAY);
    wr(`OFF_PRIMARY_CTRL, 32'hFFFFFF8E, `RESP_OKAY);
    rd(`OFF_PRIMARY_CTRL, 32'h0000000E, `RESP_OKAY);
    wr(8'h40, 32'h00000001, `RESP_SLVERR);
    rd(8'h40, 32'h0, `RESP_SLVERR);
    wr(`OFF_PRIMARY_CTRL, 32'h0, `RESP_OKAY);
    wr(`OFF_IRQ_MASK, 32'h0, `RESP_OKAY);
    // Every code on every pin, rising then falling.
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        cc = c[1:0];
        wr(`OFF_EDGE_SELECT, 32'(cc) << (2 * p), `RESP_OKAY);
        u_pins.drive(p, 1'b1);
        repeat (4) @(posedge core_clk);
        rd(`OFF_IRQ_STATUS, 32'(cc[0]) << p, `RESP_OKAY);
        wr(`OFF_IRQ_STATUS, 32'h1F, `RESP_OKAY);
        u_pins.drive(p, 1'b0);
        repeat (4) @(posedge core_clk);
        rd(`OFF_IRQ_STATUS, 32'(cc[1]) << p, `RESP_OKAY);
        wr(`OFF_IRQ_STATUS, 32'h1F, `RESP_OKAY);
      end
    end
    wr(`OFF_EDGE_SELECT, 32'h01, `RESP_OKAY);
    wr(`OFF_PRIMARY_CTRL, 32'h02, `RESP_OKAY);
    u_pins.drive(0, 1'b1);
    irq_is(1'b0);
    rd(`OFF_PRIMARY_CTRL, 32'h12, `RESP_OKAY);
    wr(`OFF_PRIMARY_CTRL, 32'h13, `RESP_OKAY);
    irq_is(1'b1);
    wr(`OFF_IRQ_MASK, 32'h0, `RESP_OKAY);
    irq_is(1'b0);
    wr(`OFF_IRQ_MASK, 32'h01, `RESP_OKAY);
    irq_is(1'b1);
    wr(`OFF_IRQ_STATUS, 32'h01, `RESP_OKAY);
    irq_is(1'b0);
    u_pins.comp0_pulse();
    rd(`OFF_IRQ_STATUS, 32'h0, `RESP_OKAY);
    wr(`OFF_PRIMARY_CTRL, 32'h48, `RESP_OKAY);
    rd(`OFF_IRQ_STATUS, 32'h04, `RESP_OKAY);
    rd(`OFF_IRQ_MASK, 32'h04, `RESP_OKAY);
    wr(`OFF_PIN3_CTRL, 32'h11, `RESP_OKAY);
    rd(`OFF_PIN3_CTRL, 32'h11, `RESP_OKAY);
    rd(`OFF_IRQ_STATUS, 32'h0C, `RESP_OKAY);
    `CHK("irq_seen", 2, u_pins.irq_seen)
    end_sim();
  end
endmodule

// file: dv/pin_partner.sv
// Model of the interrupt pins and of the core watching the request.
module pin_partner (
  input  wire logic  core_clk,
  input  wire logic  core_irq,
  output logic [3:0] pin_in,
  output logic       comp0_event
);
  timeunit 1ns;
  timeprecision 1ps;
  int irq_seen;
  initial begin
    pin_in = 4'h0;
    comp0_event = 1'b0;
    irq_seen = 0;
  end
  always @(posedge core_irq) irq_seen++;
  task automatic comp0_pulse();
    @(posedge core_clk);
    comp0_event <= 1'b1;
    @(posedge core_clk);
    comp0_event <= 1'b0;
  endtask
  task automatic drive(input int idx, input logic lvl);
    @(posedge core_clk);
    pin_in[idx] <= lvl;
  endtask
endmodule

// file: pkg/ext_irq_consts.svh
// Offsets, field positions, reset values and widths of the pin interrupt block.
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

`define AXI_ADDR_W        8
`define AXI_DATA_W        32
`define AXI_STRB_W        4
`define NUM_PINS          4
`define NUM_SRC           5

`define OFF_EDGE_SELECT   8'h00
`define OFF_PRIMARY_CTRL  8'h04
`define OFF_PIN3_CTRL     8'h08
`define OFF_IRQ_STATUS    8'h0C
`define OFF_IRQ_MASK      8'h10

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define POS_GLOBAL_EN     0
`define POS_PIN0_EN       1
`define POS_PIN1_EN       2
`define POS_SHARED_EN     3
`define POS_PIN0_FLAG     4
`define POS_PIN1_FLAG     5
`define POS_SHARED_FLAG   6
`define POS_PIN3_EN       0
`define POS_PIN3_FLAG     4

`define SRC_PIN2          2
`define SRC_PIN3          3
`define SRC_COMP0         4

`define IMPL_SRC_FOUR     5'h0F
`define IMPL_SRC_TWO      5'h13
`define IMPL_EDGE_FOUR    8'hFF
`define IMPL_EDGE_TWO     8'h0F

`define RST_EDGE_SELECT   8'h00
`define RST_FLAGS         5'h00
`define RST_ENABLES       5'h00
`define RST_GLOBAL_EN     1'b0

`endif

// file: pkg/ext_irq_pkg.sv
// Types shared by the pin interrupt block and its bus port.
package ext_irq_pkg;
  `include "ext_irq_consts.svh"

  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_code_t;

  typedef struct packed {
    logic                     en;
    logic [`AXI_ADDR_W-1:0]   addr;
    logic [`AXI_DATA_W-1:0]   data;
    logic [`AXI_STRB_W-1:0]   strb;
  } reg_wr_t;

  typedef struct packed {
    logic                     en;
    logic [`AXI_ADDR_W-1:0]   addr;
  } reg_rd_t;
endpackage

// file: rtl/axil_reg_port.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
module axil_reg_port
  import ext_irq_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [`AXI_DATA_W-1:0] wdata,
  input  wire logic [`AXI_STRB_W-1:0] wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [`AXI_DATA_W-1:0]      rdata,
  output logic [1:0]                  rresp,
  output reg_wr_t                     wr,
  input  wire logic                   wr_err,
  output reg_rd_t                     rd,
  input  wire logic [`AXI_DATA_W-1:0] rd_data,
  input  wire logic                   rd_err
);
  logic                   aw_have_q;
  logic                   w_have_q;
  logic [`AXI_ADDR_W-1:0] awaddr_q;
  logic [`AXI_DATA_W-1:0] wdata_q;
  logic [`AXI_STRB_W-1:0] wstrb_q;
  logic                   wr_go;
  logic                   rd_go;

  assign wr_go = aw_have_q & w_have_q & ~bvalid;
  assign wr    = '{en: wr_go, addr: awaddr_q, data: wdata_q, strb: wstrb_q};
  assign rd_go = arvalid & arready;
  assign rd    = '{en: rd_go, addr: araddr};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awready   <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid) begin
      awready   <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wready   <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wvalid && wready) begin
      wready   <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid) begin
      wready   <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_err ? '0 : rd_data;
      rresp   <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
endmodule

// file: rtl/ext_irq_ctrl.sv
// External pin interrupt control: edge select, request flags and enables.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
module ext_irq_ctrl
  import ext_irq_pkg::*;
#(
  parameter bit FOUR_PIN = 1'b1
)
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic [`NUM_PINS-1:0]   pin_in,
  input  wire logic                   comp0_event,
  output logic                        core_irq,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [`AXI_DATA_W-1:0] wdata,
  input  wire logic [`AXI_STRB_W-1:0] wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [`AXI_DATA_W-1:0]      rdata,
  output logic [1:0]                  rresp
);
  // Sources are indexed pin0, pin1, pin2, pin3, comparator0.
  localparam logic [`NUM_SRC-1:0] IMPL_SRC =
    FOUR_PIN ? `IMPL_SRC_FOUR : `IMPL_SRC_TWO;
  localparam logic [7:0] IMPL_EDGE =
    FOUR_PIN ? `IMPL_EDGE_FOUR : `IMPL_EDGE_TWO;
  // The shared bit pair of the primary register serves pin2 or comparator0.
  localparam int SHARED_SRC = FOUR_PIN ? `SRC_PIN2 : `SRC_COMP0;

  logic [7:0]          edge_sel_q;
  logic                global_en_q;
  logic [`NUM_SRC-1:0] flag_q;
  logic [`NUM_SRC-1:0] flag_d;
  logic [`NUM_SRC-1:0] en_q;
  logic [`NUM_SRC-1:0] en_d;
  logic [`NUM_PINS-1:0] pin_evt;
  logic [`NUM_SRC-1:0] src_evt;
  logic [`NUM_SRC-1:0] flag_wmask;
  logic [`NUM_SRC-1:0] flag_wval;
  logic [`NUM_SRC-1:0] flag_w1c;
  logic [`AXI_DATA_W-1:0] rd_data;
  logic                rd_err;
  logic                wr_err;
  logic                wr_byte;
  logic                hit_edge;
  logic                hit_prim;
  logic                hit_pin3;
  logic                hit_stat;
  logic                hit_mask;
  logic [7:0]          wbyte;
  logic [7:0]          prim_view;
  logic [7:0]          pin3_view;
  reg_wr_t             wr;
  reg_rd_t             rd;

  axil_reg_port u_port (
    .core_clk (core_clk),
    .nrst     (nrst),
    .awvalid  (awvalid),
    .awready  (awready),
    .awaddr   (awaddr),
    .wvalid   (wvalid),
    .wready   (wready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .bvalid   (bvalid),
    .bready   (bready),
    .bresp    (bresp),
    .arvalid  (arvalid),
    .arready  (arready),
    .araddr   (araddr),
    .rvalid   (rvalid),
    .rready   (rready),
    .rdata    (rdata),
    .rresp    (rresp),
    .wr       (wr),
    .wr_err   (wr_err),
    .rd       (rd),
    .rd_data  (rd_data),
    .rd_err   (rd_err)
  );

  // One detector per pin; each reads its own two-bit field.
  for (genvar p = 0; p < `NUM_PINS; p++) begin : g_pin
    pin_edge_detect u_det (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_async (pin_in[p]),
      .code      (edge_code_t'(edge_sel_q[2*p+1 -: 2])),
      .evt       (pin_evt[p])
    );
  end

  // Pins 2 and 3 exist only in the four-pin variant.
  assign src_evt = {comp0_event, pin_evt} & IMPL_SRC;

  // Write address decode.
  assign hit_edge = wr.addr == `OFF_EDGE_SELECT;
  assign hit_prim = wr.addr == `OFF_PRIMARY_CTRL;
  assign hit_pin3 = FOUR_PIN && (wr.addr == `OFF_PIN3_CTRL);
  assign hit_stat = wr.addr == `OFF_IRQ_STATUS;
  assign hit_mask = wr.addr == `OFF_IRQ_MASK;
  assign wr_err   = ~(hit_edge | hit_prim | hit_pin3 | hit_stat | hit_mask);
  // Registers are one byte wide and only byte lane 0 reaches them.
  assign wr_byte  = wr.en & wr.strb[0];
  assign wbyte    = wr.data[7:0];

  // Edge select register: unimplemented fields stay zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      edge_sel_q <= `RST_EDGE_SELECT;
    end else if (wr_byte && hit_edge) begin
      edge_sel_q <= wbyte & IMPL_EDGE;
    end
  end

  // Global enable.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      global_en_q <= `RST_GLOBAL_EN;
    end else if (wr_byte && hit_prim) begin
      global_en_q <= wbyte[`POS_GLOBAL_EN];
    end
  end

  // Direct flag writes from the primary and pin3 registers.
  always_comb begin
    flag_wmask = '0;
    flag_wval  = '0;
    flag_w1c   = '0;
    if (wr_byte && hit_prim) begin
      flag_wmask[0]          = 1'b1;
      flag_wmask[1]          = 1'b1;
      flag_wmask[SHARED_SRC] = 1'b1;
      flag_wval[0]           = wbyte[`POS_PIN0_FLAG];
      flag_wval[1]           = wbyte[`POS_PIN1_FLAG];
      flag_wval[SHARED_SRC]  = wbyte[`POS_SHARED_FLAG];
    end
    if (wr_byte && hit_pin3) begin
      flag_wmask[`SRC_PIN3]  = 1'b1;
      flag_wval[`SRC_PIN3]   = wbyte[`POS_PIN3_FLAG];
    end
    if (wr_byte && hit_stat) begin
      flag_w1c = wbyte[`NUM_SRC-1:0];
    end
  end

  // A detected edge wins over any clear in the same cycle.
  assign flag_d = ((((flag_q & ~flag_wmask) | (flag_wval & flag_wmask))
                   & ~flag_w1c) | src_evt) & IMPL_SRC;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= `RST_FLAGS;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Enables are written through the primary, pin3 or mask registers.
  always_comb begin
    en_d = en_q;
    if (wr_byte && hit_prim) begin
      en_d[0]          = wbyte[`POS_PIN0_EN];
      en_d[1]          = wbyte[`POS_PIN1_EN];
      en_d[SHARED_SRC] = wbyte[`POS_SHARED_EN];
    end
    if (wr_byte && hit_pin3) begin
      en_d[`SRC_PIN3]  = wbyte[`POS_PIN3_EN];
    end
    if (wr_byte && hit_mask) begin
      en_d = wbyte[`NUM_SRC-1:0];
    end
    en_d = en_d & IMPL_SRC;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= `RST_ENABLES;
    end else begin
      en_q <= en_d;
    end
  end

  // The core sees a request only for an enabled, flagged source.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      core_irq <= 1'b0;
    end else begin
      core_irq <= global_en_q & |(flag_q & en_q);
    end
  end

  // Register views; bit 7 and unused positions read zero.
  always_comb begin
    prim_view                   = 8'h00;
    prim_view[`POS_GLOBAL_EN]   = global_en_q;
    prim_view[`POS_PIN0_EN]     = en_q[0];
    prim_view[`POS_PIN1_EN]     = en_q[1];
    prim_view[`POS_SHARED_EN]   = en_q[SHARED_SRC];
    prim_view[`POS_PIN0_FLAG]   = flag_q[0];
    prim_view[`POS_PIN1_FLAG]   = flag_q[1];
    prim_view[`POS_SHARED_FLAG] = flag_q[SHARED_SRC];
  end

  always_comb begin
    pin3_view                 = 8'h00;
    pin3_view[`POS_PIN3_EN]   = en_q[`SRC_PIN3];
    pin3_view[`POS_PIN3_FLAG] = flag_q[`SRC_PIN3];
  end

  // Read decode; unmapped addresses answer with an error and zero data.
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (rd.addr)
      `OFF_EDGE_SELECT:  rd_data[7:0] = edge_sel_q;
      `OFF_PRIMARY_CTRL: rd_data[7:0] = prim_view;
      `OFF_PIN3_CTRL: begin
        if (FOUR_PIN) begin
          rd_data[7:0] = pin3_view;
        end else begin
          rd_err = 1'b1;
        end
      end
      `OFF_IRQ_STATUS:   rd_data[`NUM_SRC-1:0] = flag_q;
      `OFF_IRQ_MASK:     rd_data[`NUM_SRC-1:0] = en_q;
      default:           rd_err = 1'b1;
    endcase
  end
endmodule

// file: rtl/pin_edge_detect.sv
// Synchronises one interrupt pin and flags the edges its code selects.
module pin_edge_detect
  import ext_irq_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       pin_async,
  input  wire edge_code_t code,
  output logic            evt
);
  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic [2:0] prime_q;
  logic       rise;
  logic       fall;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin_async;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Holds off detection until the history holds a real pin level.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prime_q <= 3'h0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  assign rise = prime_q[2] & sync2_q & ~prev_q;
  assign fall = prime_q[2] & ~sync2_q & prev_q;

  always_comb begin
    case (code)
      EDGE_OFF:  evt = 1'b0;
      EDGE_RISE: evt = rise;
      EDGE_FALL: evt = fall;
      EDGE_BOTH: evt = rise | fall;
      default:   evt = 1'b0;
    endcase
  end
endmodule
